// File: dtp_timer.sv
// Functional notes
// - two 32-bit period halves, one per counter
// - period halves read/write, reset to zero
// - edge select: rise, fall, both; 3 reserved
// - capture only unchained, internal clock, continuous or reload
// - capture event resets upper counter when enabled
// - capture event raises interrupt and dma event
// - read of upper count clears when enabled
// - clear by read raises no event
// - clear on read only when unchained
// - gate starts on pin rise, stops on fall
// - gating applies to internal clock only
// - clock source: 0 internal, 1 input pin
// - control bits 29-22 upper fields, 31-30 zero
// - counter halves read/write, reset zero, show count
// - continuous: count to period, then zero; reload
module dtp_timer
   import dtp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [DTP_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic timer_input_pin_lower,
   input wire logic timer_input_pin_upper,
   output logic irq,
   output logic [1:0] event_out
);
   typedef struct packed {
      logic wreq;
      logic [31:0] rdata;
      logic [1:0][31:0] prd;
      logic [1:0][31:0] rel;
      logic [31:0] ctl;
      logic chain;
      logic [3:0] sts;
      logic [3:0] ien;
      logic irq;
      logic [1:0] evt;
      logic [1:0] gate_run;
   } dtp_main_t;

   dtp_main_t st_ff;
   dtp_main_t nxt_st;

   logic [1:0] pin_rise;
   logic [1:0] pin_fall;
   logic [1:0][31:0] cnt;
   logic [1:0] cinc;
   logic [1:0] cclr;
   logic [1:0] cwr;
   logic [1:0][31:0] cwdata;
   logic [1:0] tick;
   logic [1:0] cap_evt;
   logic [1:0] rd_clr;
   logic [1:0] prd_evt;
   logic [1:0][1:0] mode;
   logic [1:0] match;
   logic match64;
   logic acc;
   logic [3:0] sts_set;

   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pins and counter halves

   for (genvar h = 0; h < 2; h++) begin : g_half
      dtp_pin_sync u_sync (
         .ref_clk(ref_clk),
         .rst_n(rst_n),
         .pin(h == 0 ? timer_input_pin_lower : timer_input_pin_upper),
         .level(),
         .rise(pin_rise[h]),
         .fall(pin_fall[h])
      );
      dtp_count_half #(.WIDTH(DTP_DATA_W)) u_cnt (
         .ref_clk(ref_clk),
         .rst_n(rst_n),
         .inc(cinc[h]),
         .clr(cclr[h]),
         .wr_en(cwr[h]),
         .wr_data(cwdata[h]),
         .count(cnt[h])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   // an access takes two cycles: read data is taken in the first, waitrequest drops for the second, where writes and read clears act
   assign acc = (avs_read | avs_write) & ~st_ff.wreq;

   always_comb begin
      logic [5:0] sh;
      logic gate_en;
      logic src_ext;
      logic rdclr_en;
      logic cap_en;
      logic [1:0] cap_sel;
      logic edge_hit;
      sh = 6'h00;
      gate_en = 1'b0;
      src_ext = 1'b0;
      rdclr_en = 1'b0;
      cap_en = 1'b0;
      cap_sel = 2'h0;
      edge_hit = 1'b0;
      nxt_st = st_ff;
      sts_set = 4'h0;
      match64 = ({cnt[1], cnt[0]} == {st_ff.prd[1], st_ff.prd[0]});
      for (int h = 0; h < 2; h++) begin
         sh = 6'(h * DTP_HALF_SHIFT);
         mode[h] = st_ff.ctl[DTP_POS_ENA + sh +: 2];
         src_ext = st_ff.ctl[DTP_POS_CLOCK_SOURCE_SELECT + sh];
         gate_en = st_ff.ctl[DTP_POS_GATE + sh];
         rdclr_en = st_ff.ctl[DTP_POS_RDCLR + sh];
         cap_en = st_ff.ctl[DTP_POS_CAPEN + sh];
         cap_sel = st_ff.ctl[DTP_POS_CAPEDGE + sh +: 2];
         match[h] = (cnt[h] == st_ff.prd[h]);
         // the gate state follows the pin whether or not gating is on
         if (pin_rise[h]) begin
            nxt_st.gate_run[h] = 1'b1;
         end else if (pin_fall[h]) begin
            nxt_st.gate_run[h] = 1'b0;
         end
         if (src_ext) begin
            tick[h] = pin_rise[h];
         end else begin
            tick[h] = gate_en ? st_ff.gate_run[h] : 1'b1;
         end
         case (cap_sel)
            DTP_EDGE_RISE: edge_hit = pin_rise[h];
            DTP_EDGE_FALL: edge_hit = pin_fall[h];
            DTP_EDGE_BOTH: edge_hit = pin_rise[h] | pin_fall[h];
            default: edge_hit = 1'b0;
         endcase
         cap_evt[h] = ~st_ff.chain & ~src_ext & mode[h][1] & cap_en & edge_hit;
         rd_clr[h] = ~st_ff.chain & rdclr_en & acc & avs_read
                     & (avs_address == (h == 0 ? DTP_OFS_CNT_LO : DTP_OFS_CNT_HI));
         cwr[h] = acc & avs_write
                  & (avs_address == (h == 0 ? DTP_OFS_CNT_LO : DTP_OFS_CNT_HI));
         cwdata[h] = be_merge(cnt[h], avs_writedata, avs_byteenable);
         cinc[h] = 1'b0;
         cclr[h] = cap_evt[h] | rd_clr[h];
         prd_evt[h] = 1'b0;
      end
      if (st_ff.chain) begin
         // lower controls steer the 64-bit timer
         if (tick[0] && mode[0] != DTP_ENA_OFF) begin
            if (match64) begin
               if (mode[0][1]) begin
                  cclr = 2'b11;
                  if (mode[0] == DTP_ENA_RELOAD) begin
                     nxt_st.prd = st_ff.rel;
                  end
               end
            end else begin
               cinc[0] = 1'b1;
               cinc[1] = &cnt[0];
               prd_evt[0] = (({cnt[1], cnt[0]} + 64'h1) == {st_ff.prd[1], st_ff.prd[0]});
            end
         end
      end else begin
         for (int h = 0; h < 2; h++) begin
            if (tick[h] && mode[h] != DTP_ENA_OFF && !cap_evt[h] && !rd_clr[h]) begin
               if (match[h]) begin
                  if (mode[h][1]) begin
                     cclr[h] = 1'b1;
                     if (mode[h] == DTP_ENA_RELOAD) begin
                        nxt_st.prd[h] = st_ff.rel[h];
                     end
                  end
               end else begin
                  cinc[h] = 1'b1;
                  prd_evt[h] = ((cnt[h] + 32'h1) == st_ff.prd[h]);
               end
            end
         end
      end
      // read clears are deliberately absent from the event sources
      sts_set[DTP_IRQ_PRD_LO] = prd_evt[0];
      sts_set[DTP_IRQ_CAP_LO] = cap_evt[0];
      sts_set[DTP_IRQ_PRD_HI] = prd_evt[1];
      sts_set[DTP_IRQ_CAP_HI] = cap_evt[1];
      nxt_st.evt = prd_evt | cap_evt;

      // bus slave
      nxt_st.wreq = ~((avs_read | avs_write) & st_ff.wreq);
      if (avs_read && st_ff.wreq) begin
         case (avs_address)
            DTP_OFS_CNT_LO: nxt_st.rdata = cnt[0];
            DTP_OFS_CNT_HI: nxt_st.rdata = cnt[1];
            DTP_OFS_PRD_LO: nxt_st.rdata = st_ff.prd[0];
            DTP_OFS_PRD_HI: nxt_st.rdata = st_ff.prd[1];
            DTP_OFS_CTL: nxt_st.rdata = st_ff.ctl & DTP_CTL_WMASK;
            DTP_OFS_REL_LO: nxt_st.rdata = st_ff.rel[0];
            DTP_OFS_REL_HI: nxt_st.rdata = st_ff.rel[1];
            DTP_OFS_CHAIN: nxt_st.rdata = {31'h0, st_ff.chain};
            DTP_OFS_ISTS: nxt_st.rdata = {28'h0, st_ff.sts};
            DTP_OFS_IEN: nxt_st.rdata = {28'h0, st_ff.ien};
            default: nxt_st.rdata = DTP_RST_WORD;
         endcase
      end
      nxt_st.sts = st_ff.sts;
      if (acc && avs_write) begin
         case (avs_address)
            DTP_OFS_PRD_LO: nxt_st.prd[0] = be_merge(st_ff.prd[0], avs_writedata,
                                                     avs_byteenable);
            DTP_OFS_PRD_HI: nxt_st.prd[1] = be_merge(st_ff.prd[1], avs_writedata,
                                                     avs_byteenable);
            DTP_OFS_CTL: nxt_st.ctl = be_merge(st_ff.ctl, avs_writedata, avs_byteenable)
                                      & DTP_CTL_WMASK;
            DTP_OFS_REL_LO: nxt_st.rel[0] = be_merge(st_ff.rel[0], avs_writedata, avs_byteenable);
            DTP_OFS_REL_HI: nxt_st.rel[1] = be_merge(st_ff.rel[1], avs_writedata, avs_byteenable);
            DTP_OFS_CHAIN: nxt_st.chain = avs_byteenable[0] ? avs_writedata[0] : st_ff.chain;
            DTP_OFS_ICLR: nxt_st.sts = st_ff.sts & ~(avs_writedata[3:0] & {4{avs_byteenable[0]}});
            DTP_OFS_IEN: nxt_st.ien = avs_byteenable[0] ? avs_writedata[3:0] : st_ff.ien;
            default: nxt_st.chain = st_ff.chain;
         endcase
      end
      // a new event beats a clear in the same cycle
      nxt_st.sts = nxt_st.sts | sts_set;
      nxt_st.irq = |(nxt_st.sts & nxt_st.ien);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.wreq <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign avs_readdata = st_ff.rdata;
   assign avs_waitrequest = st_ff.wreq;
   assign irq = st_ff.irq;
   assign event_out = st_ff.evt;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_prd_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_n)
      acc && avs_write && avs_address == DTP_OFS_PRD_HI && avs_byteenable == 4'hf
      |=> st_ff.prd[1] == $past(avs_writedata))
      else $error("period high write lost");

   a_cap_resets_upper: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cap_evt[1] && !cwr[1] |=> cnt[1] == 32'h0)
      else $error("capture did not clear upper counter");

   a_cap_needs_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cap_evt[1] |-> !st_ff.chain && !st_ff.ctl[24] && st_ff.ctl[23])
      else $error("capture outside its mode");

   a_cap_raises_event: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cap_evt[1] |=> event_out[1] && st_ff.sts[DTP_IRQ_CAP_HI])
      else $error("capture raised no event");

   a_rdclr_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_clr[1] |=> cnt[1] == 32'h0)
      else $error("read clear failed");

   a_rdclr_silent: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_clr[1] && !cap_evt[1] |=> !event_out[1])
      else $error("read clear raised an event");

   a_rdclr_chain_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_ff.chain |-> rd_clr == 2'b00)
      else $error("read clear while chained");

   a_gate_stops: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pin_fall[1] |=> !st_ff.gate_run[1] && (!st_ff.ctl[25] || st_ff.ctl[24] || !tick[1]))
      else $error("gate did not stop counting");

   a_ext_clk_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !st_ff.chain && st_ff.ctl[24] && !pin_rise[1] |-> !cinc[1])
      else $error("external clock counted without edge");

   a_ctl_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_ff.ctl[31:30] == 2'b00 && st_ff.ctl[15:14] == 2'b00)
      else $error("reserved control bits set");

   a_cont_wraps: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !st_ff.chain && tick[0] && mode[0] == DTP_ENA_CONT && match[0] && !cwr[0]
      |=> cnt[0] == 32'h0)
      else $error("continuous mode did not wrap");

   a_chain_wraps: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_ff.chain && tick[0] && mode[0][1] && match64 && cwr == 2'b00
      |=> cnt[0] == 32'h0 && cnt[1] == 32'h0)
      else $error("chained timer did not wrap");

   a_edge_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_ff.ctl[29:28] == 2'h3 |-> !cap_evt[1])
      else $error("reserved edge choice captured");

   a_cap_lower_event: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cap_evt[0] |=> event_out[0] && st_ff.sts[DTP_IRQ_CAP_LO])
      else $error("lower capture raised no event");

   a_cap_lower_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cap_evt[0] && !cwr[0] |=> cnt[0] == 32'h0)
      else $error("capture did not clear lower counter");

   // a running upper half with no clear pending must step by exactly one
   a_cnt_increments: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !st_ff.chain && tick[1] && mode[1] != DTP_ENA_OFF && !match[1] && !cclr[1] && !cwr[1]
      |=> cnt[1] == $past(cnt[1]) + 32'h1)
      else $error("upper counter did not step");
endmodule

// File: dtp_pkg.sv
package dtp_pkg;
   localparam int DTP_DATA_W = 32;
   localparam int DTP_ADDR_W = 6;
   // register byte offsets
   localparam logic [5:0] DTP_OFS_CNT_LO = 6'h00;
   localparam logic [5:0] DTP_OFS_CNT_HI = 6'h04;
   localparam logic [5:0] DTP_OFS_PRD_LO = 6'h08;
   localparam logic [5:0] DTP_OFS_PRD_HI = 6'h0c;
   localparam logic [5:0] DTP_OFS_CTL = 6'h10;
   localparam logic [5:0] DTP_OFS_REL_LO = 6'h14;
   localparam logic [5:0] DTP_OFS_REL_HI = 6'h18;
   localparam logic [5:0] DTP_OFS_CHAIN = 6'h1c;
   localparam logic [5:0] DTP_OFS_ISTS = 6'h20;
   localparam logic [5:0] DTP_OFS_ICLR = 6'h24;
   localparam logic [5:0] DTP_OFS_IEN = 6'h28;
   // reset values
   localparam logic [31:0] DTP_RST_WORD = 32'h0000_0000;
   localparam logic [3:0] DTP_RST_IRQ = 4'h0;
   // control word: lower-half field positions, upper half sits this far above
   localparam int DTP_HALF_SHIFT = 16;
   localparam int DTP_POS_ENA = 6;
   localparam int DTP_POS_CLOCK_SOURCE_SELECT = 8;
   localparam int DTP_POS_GATE = 9;
   localparam int DTP_POS_RDCLR = 10;
   localparam int DTP_POS_CAPEN = 11;
   localparam int DTP_POS_CAPEDGE = 12;
   // writable bits; reserved bits and the output state bits read zero
   localparam logic [31:0] DTP_CTL_WMASK = 32'h3ffe_3ffe;
   // enable modes
   localparam logic [1:0] DTP_ENA_OFF = 2'h0;
   localparam logic [1:0] DTP_ENA_ONCE = 2'h1;
   localparam logic [1:0] DTP_ENA_CONT = 2'h2;
   localparam logic [1:0] DTP_ENA_RELOAD = 2'h3;
   // capture edge selections
   localparam logic [1:0] DTP_EDGE_RISE = 2'h0;
   localparam logic [1:0] DTP_EDGE_FALL = 2'h1;
   localparam logic [1:0] DTP_EDGE_BOTH = 2'h2;
   // interrupt status bit positions
   localparam int DTP_IRQ_PRD_LO = 0;
   localparam int DTP_IRQ_CAP_LO = 1;
   localparam int DTP_IRQ_PRD_HI = 2;
   localparam int DTP_IRQ_CAP_HI = 3;
endpackage

// File: dtp_pin_sync.sv
module dtp_pin_sync
   import dtp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } dtp_sync_t;

   dtp_sync_t st_ff;
   dtp_sync_t nxt_st;

   always_comb begin
      nxt_st.s1 = pin;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // edges look only at the second and third stage
   assign level = st_ff.s2;
   assign rise = st_ff.s2 & ~st_ff.s3;
   assign fall = ~st_ff.s2 & st_ff.s3;
endmodule

// File: dtp_count_half.sv
module dtp_count_half
   import dtp_pkg::*;
#(
   parameter int WIDTH = DTP_DATA_W
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic inc,
   input wire logic clr,
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   output logic [WIDTH-1:0] count
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } dtp_cnt_t;

   dtp_cnt_t st_ff;
   dtp_cnt_t nxt_st;

   // software write wins over clear, clear over increment
   always_comb begin
      nxt_st = st_ff;
      if (wr_en) begin
         nxt_st.cnt = wr_data;
      end else if (clr) begin
         nxt_st.cnt = '0;
      end else if (inc) begin
         nxt_st.cnt = st_ff.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign count = st_ff.cnt;
endmodule

// File: dtp_pin_model.sv
module dtp_pin_model (
   input wire logic ref_clk,
   output logic pin_lower,
   output logic pin_upper
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      pin_lower = 1'b0;
      pin_upper = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // the pin moves just after an edge, like a synchronous source upstream
   task automatic set_upper(input logic v);
      @(posedge ref_clk);
      pin_upper <= v;
   endtask

   task automatic set_lower(input logic v);
      @(posedge ref_clk);
      pin_lower <= v;
   endtask

   // each phase spans four cycles so the three-flop synchroniser cannot miss it
   task automatic clock_upper(input int n);
      repeat (n) begin
         set_upper(1'b1);
         repeat (3) @(posedge ref_clk);
         set_upper(1'b0);
         repeat (3) @(posedge ref_clk);
      end
   endtask
endmodule

// File: dual_timer_period_control_tb.sv
module dual_timer_period_control_tb
   import dtp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, irq, pin_lower, pin_upper;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd, a;
   logic [3:0] avs_byteenable;
   logic [1:0] event_out;
   logic [5:0] ofs [5];
   int fail_count, cmp_count, cyc, d;

   dtp_timer dtp_timer_i (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .timer_input_pin_lower(pin_lower),
      .timer_input_pin_upper(pin_upper), .irq(irq), .event_out(event_out));
   dtp_pin_model dtp_pin_model_i (.ref_clk(ref_clk), .pin_lower(pin_lower),
      .pin_upper(pin_upper));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // values sampled right after the edge are the pre-edge ones the slave presented
   task automatic acc(input logic w, input logic [5:0] ad, input logic [31:0] wd);
      avs_address <= ad;
      avs_writedata <= wd;
      avs_write <= w;
      avs_read <= !w;
      // no limit of its own: a slave that never answers runs into the bench timeout
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // idle edge so the next request is a fresh one, not a held one
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [5:0] ad, input logic [31:0] wd);
      acc(1'b1, ad, wd);
   endtask

   task automatic rdc(input string nm, input logic [5:0] ad, input logic [31:0] e);
      acc(1'b0, ad, 32'h0);
      chk(nm, e, rd);
   endtask

   // cycles between two one-cycle event pulses of one half
   task automatic gap(input int i, output int g);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (event_out[i] !== 1'b1 && n < 200);
      g = 0;
      do begin
         @(posedge ref_clk);
         g++;
      end while (event_out[i] !== 1'b1 && g < 200);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         end_of_test();
      end
   end

   initial begin
      rst_n = 1'b0;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      ofs = '{DTP_OFS_CNT_LO, DTP_OFS_CNT_HI, DTP_OFS_PRD_LO, DTP_OFS_PRD_HI, DTP_OFS_CTL};
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 5; i++) rdc("reset_value", ofs[i], DTP_RST_WORD);
      wr(DTP_OFS_PRD_LO, 32'hffff_ffff);
      wr(DTP_OFS_PRD_HI, 32'h1234_abcd);
      rdc("period_low", DTP_OFS_PRD_LO, 32'hffff_ffff);
      rdc("period_high", DTP_OFS_PRD_HI, 32'h1234_abcd);
      avs_byteenable <= 4'h2;
      wr(DTP_OFS_PRD_LO, 32'h0000_5a00);
      avs_byteenable <= 4'hf;
      rdc("byte_lane", DTP_OFS_PRD_LO, 32'hffff_5aff);
      wr(DTP_OFS_CTL, 32'hffff_ffff);
      rdc("control_mask", DTP_OFS_CTL, DTP_CTL_WMASK);
      wr(DTP_OFS_CTL, 32'h0);
      rdc("unmapped", 6'h3c, 32'h0);
      // clear on read, counter stopped so only the read can change it
      wr(DTP_OFS_CNT_HI, 32'h55);
      wr(DTP_OFS_CTL, 32'h0400_0000);
      rdc("rdclr_first", DTP_OFS_CNT_HI, 32'h55);
      rdc("rdclr_second", DTP_OFS_CNT_HI, 32'h0);
      rdc("rdclr_no_event", DTP_OFS_ISTS, 32'h0);
      wr(DTP_OFS_CTL, 32'h0);
      wr(DTP_OFS_CNT_HI, 32'h66);
      rdc("rdclr_off_a", DTP_OFS_CNT_HI, 32'h66);
      rdc("rdclr_off_b", DTP_OFS_CNT_HI, 32'h66);
      wr(DTP_OFS_CHAIN, 32'h1);
      wr(DTP_OFS_CTL, 32'h0400_0000);
      wr(DTP_OFS_CNT_HI, 32'h77);
      rdc("chained_a", DTP_OFS_CNT_HI, 32'h77);
      rdc("chained_b", DTP_OFS_CNT_HI, 32'h77);
      wr(DTP_OFS_CHAIN, 32'h0);
      // capture: unchained, internal clock, continuous mode, each edge choice
      wr(DTP_OFS_IEN, 32'h8);
      // -1 stands for the reserved edge choice; the both-edges pass runs last
      for (int e = -1; e < 3; e++) begin
         wr(DTP_OFS_CTL, 32'h0);
         wr(DTP_OFS_ICLR, 32'hf);
         wr(DTP_OFS_CTL, (32'(2'(e)) << 28) | 32'h0880_0000);
         repeat (60) @(posedge ref_clk);
         dtp_pin_model_i.set_upper(1'b1);
         repeat (10) @(posedge ref_clk);
         chk("irq_rise", 32'(e == 0 || e == 2), 32'(irq));
         rdc("cap_rise", DTP_OFS_ISTS, (e == 0 || e == 2) ? 32'h8 : 32'h0);
         acc(1'b0, DTP_OFS_CNT_HI, 32'h0);
         chk("cap_count", 32'(e == 0 || e == 2), 32'(rd < 32'd30));
         wr(DTP_OFS_ICLR, 32'hf);
         dtp_pin_model_i.set_upper(1'b0);
         repeat (10) @(posedge ref_clk);
         rdc("cap_fall", DTP_OFS_ISTS, (e == 1 || e == 2) ? 32'h8 : 32'h0);
      end
      wr(DTP_OFS_IEN, 32'h0);
      chk("irq_masked", 32'h0, 32'(irq));
      wr(DTP_OFS_IEN, 32'h8);
      chk("irq_enabled", 32'h1, 32'(irq));
      wr(DTP_OFS_ICLR, 32'hf);
      chk("irq_cleared", 32'h0, 32'(irq));
      // capture enable off: an edge leaves the counter running
      wr(DTP_OFS_CTL, 32'h0080_0000);
      dtp_pin_model_i.set_upper(1'b1);
      repeat (40) @(posedge ref_clk);
      acc(1'b0, DTP_OFS_CNT_HI, 32'h0);
      chk("no_capture", 32'h1, 32'(rd > 32'd40));
      dtp_pin_model_i.set_upper(1'b0);
      // gate: counts only between a rising and a falling pin edge
      wr(DTP_OFS_CTL, 32'h0280_0000);
      wr(DTP_OFS_CNT_HI, 32'h0);
      repeat (30) @(posedge ref_clk);
      rdc("gate_closed", DTP_OFS_CNT_HI, 32'h0);
      dtp_pin_model_i.set_upper(1'b1);
      repeat (40) @(posedge ref_clk);
      acc(1'b0, DTP_OFS_CNT_HI, 32'h0);
      chk("gate_open", 32'h1, 32'(rd >= 32'd30));
      dtp_pin_model_i.set_upper(1'b0);
      repeat (5) @(posedge ref_clk);
      acc(1'b0, DTP_OFS_CNT_HI, 32'h0);
      a = rd;
      repeat (30) @(posedge ref_clk);
      rdc("gate_stopped", DTP_OFS_CNT_HI, a);
      // external clock: one count per pin pulse
      wr(DTP_OFS_CTL, 32'h0180_0000);
      wr(DTP_OFS_CNT_HI, 32'h0);
      dtp_pin_model_i.clock_upper(5);
      repeat (5) @(posedge ref_clk);
      rdc("ext_clock", DTP_OFS_CNT_HI, 32'h5);
      // lower half capture on its own pin, rising edge
      wr(DTP_OFS_ICLR, 32'hf);
      wr(DTP_OFS_CTL, 32'h0000_0880);
      dtp_pin_model_i.set_lower(1'b1);
      repeat (10) @(posedge ref_clk);
      rdc("cap_lower", DTP_OFS_ISTS, 32'h2);
      chk("irq_lower_masked", 32'h0, 32'(irq));
      dtp_pin_model_i.set_lower(1'b0);
      // continuous mode: period p gives an event every p+1 cycles, halves independent
      wr(DTP_OFS_CTL, 32'h0);
      wr(DTP_OFS_CNT_LO, 32'h0);
      wr(DTP_OFS_CNT_HI, 32'h0);
      wr(DTP_OFS_PRD_LO, 32'h9);
      wr(DTP_OFS_PRD_HI, 32'h4);
      wr(DTP_OFS_CTL, 32'h0080_0080);
      gap(0, d);
      chk("period_low_gap", 32'd10, 32'(d));
      gap(1, d);
      chk("period_high_gap", 32'd5, 32'(d));
      end_of_test();
   end
endmodule
